// >>> include/isp_pkg.sv
// Shared constants and types for the serial programming link ends
package isp_pkg;

	// ******************************************************
	// Clock and wait times
	// ******************************************************
	localparam int CLK_PERIOD_NS  = 4;          // 250 MHz system clock
	localparam int FLASH_WAIT_NS  = 4_500_000;  // flash_write_wait, 4.5 ms
	localparam int EEPROM_WAIT_NS = 3_600_000;  // eeprom_write_wait, 3.6 ms
	localparam int ERASE_WAIT_NS  = 9_000_000;  // erase_wait, 9.0 ms
	localparam int ENTRY_WAIT_NS  = 20_000_000; // Settle time after reset, 20 ms
	// Least times round up to whole cycles
	localparam int FLASH_WAIT_CYC  =
		(FLASH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EEPROM_WAIT_CYC =
		(EEPROM_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_WAIT_CYC  =
		(ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENTRY_WAIT_CYC  =
		(ENTRY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCK_HALF_CYC  = 4'h8; // Serial clock half period
	localparam logic [3:0] RST_PULSE_CYC = 4'h4; // Resync reset pulse width

	// ******************************************************
	// Memory geometry
	// ******************************************************
	localparam int FL_ADDR_W  = 13; // Flash word address
	localparam int FL_WORD_W  = 6;  // Word within a flash page
	localparam int EE_ADDR_W  = 9;  // EEPROM byte address
	localparam int EE_BYTE_W  = 2;  // Byte within an EEPROM page
	localparam logic [7:0] FUSE_RST = 8'hff; // Fuses and lock unprogrammed

	// ******************************************************
	// Instruction bytes
	// ******************************************************
	localparam logic [7:0] OP_SPECIAL    = 8'hac;
	localparam logic [7:0] SUB_ENABLE    = 8'h53;
	localparam logic [7:0] SUB_ERASE     = 8'h80;
	localparam logic [7:0] SUB_WR_LOCK   = 8'he0;
	localparam logic [7:0] SUB_WR_FLO    = 8'ha0;
	localparam logic [7:0] SUB_WR_FHI    = 8'ha8;
	localparam logic [7:0] SUB_WR_FEXT   = 8'ha4;
	localparam logic [7:0] OP_POLL       = 8'hf0;
	localparam logic [7:0] OP_LD_FL_LO   = 8'h40;
	localparam logic [7:0] OP_LD_FL_HI   = 8'h48;
	localparam logic [7:0] OP_LD_EE      = 8'hc1;
	localparam logic [7:0] OP_RD_FL_LO   = 8'h20;
	localparam logic [7:0] OP_RD_FL_HI   = 8'h28;
	localparam logic [7:0] OP_RD_EE      = 8'ha0;
	localparam logic [7:0] OP_RD_LOCK_FH = 8'h58;
	localparam logic [7:0] OP_RD_FUSE_FE = 8'h50;
	localparam logic [7:0] SUB_RD_ALT    = 8'h08;
	localparam logic [7:0] OP_RD_SIG     = 8'h30;
	localparam logic [7:0] OP_RD_CAL     = 8'h38;
	localparam logic [7:0] OP_WR_FL_PAGE = 8'h4c;
	localparam logic [7:0] OP_WR_EE      = 8'hc0;
	localparam logic [7:0] OP_WR_EE_PAGE = 8'hc2;

	// ******************************************************
	// State enumerations
	// ******************************************************
	typedef enum logic [1:0] {DS_IDLE, DS_ERASE, DS_FLASH, DS_WAIT}
		isp_dev_st_t;
	typedef enum logic [1:0] {PS_IDLE, PS_SHIFT, PS_PULSE} isp_prog_st_t;

endpackage

// >>> include/isp_if.sv
// Serial programming link between programmer and target
`timescale 1ns/100ps
interface isp_if;
	logic sck;        // Serial clock, made by the programmer
	logic mosi;       // Data toward the target
	logic miso;       // Data toward the programmer
	logic targetRstN; // Target reset, low selects programming mode
	modport dev  (input sck, input mosi, input targetRstN, output miso);
	modport prog (output sck, output mosi, output targetRstN, input miso);
endinterface

// >>> verilog/isp_target.sv
// Target end: serial programming command engine with its memories
//
// Contract
// - Only enable unlocks program and erase
// - EEPROM byte write erases then writes
// - Chip erase sets flash, EEPROM to ones
// - Programmer keeps clock phases over minimum
// - Capture input bit on clock rise
// - Shift output bit on clock fall
// - Programmer holds reset, clock low initially
// - Programmer waits 20 ms before enable
// - Echo enable second byte; send four bytes
// - No echo: pulse reset, resend enable; programmer only pulses reset and raises syncFail
// - Load page buffer bytes by low bits
// - Programmer loads low byte before high
// - Page write selects page by upper bits
// - Programmer waits write times without polling; the programmer has no write timer, the bench polls instead
// - Poll returns busy in bit zero
// - EEPROM byte write stores given byte
// - EEPROM page alters only loaded bytes
// - Reads answer during the fourth byte
// - Flash read low/high byte by opcode
// - Decode fuse, lock, signature, calibration reads
// - Fuse and lock writes take byte four
// - Flash addresses are word addresses
`timescale 1ns/100ps
module isp_target
	import isp_pkg::*;
#(
	parameter int         FLASH_WAIT  = FLASH_WAIT_CYC,
	parameter int         EEPROM_WAIT = EEPROM_WAIT_CYC,
	parameter int         ERASE_WAIT  = ERASE_WAIT_CYC,
	parameter logic [7:0] SIG_BYTE0   = 8'h1e, // Arbitrary identity value
	parameter logic [7:0] SIG_BYTE1   = 8'h55, // Arbitrary identity value
	parameter logic [7:0] SIG_BYTE2   = 8'h0a, // Arbitrary identity value
	parameter logic [7:0] CAL_BYTE    = 8'h80  // Arbitrary calibration
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clkEn,
	isp_if.dev              bus,
	output logic            progMode,
	output logic            busy,
	output logic [7:0]      lockBits,
	output logic [7:0]      fuseLo,
	output logic [7:0]      fuseHi,
	output logic [7:0]      fuseExt
);

	// ******************************************************
	// State
	// ******************************************************
	typedef struct packed {
		logic [2:0]  sckSync;  // [0] first stage, [2] edge history
		logic [1:0]  mosiSync; // Data input synchroniser
		logic [1:0]  rstSync;  // Target reset synchroniser
		logic [31:0] rxSh;     // Incoming instruction bits
		logic [4:0]  bitCnt;   // Bits of the current instruction
		logic [7:0]  txSh;     // Outgoing byte
		logic        miso;     // Output pin register
		logic        enabled;  // Programming enable received
		logic        busy;     // Operation pending
		isp_dev_st_t st;       // Nonvolatile operation phase
		logic [12:0] sweep;    // Erase and page commit index
		logic [23:0] waitCnt;  // Self-timed write delay
		logic [6:0]  flPage;   // Flash page being committed
		logic [3:0]  eeLoaded; // EEPROM page bytes loaded
		logic [7:0]  lockBits;
		logic [7:0]  fuseLo;
		logic [7:0]  fuseHi;
		logic [7:0]  fuseExt;
	} isp_target_state_t;

	isp_target_state_t state_reg;  // Registered state
	isp_target_state_t state_next; // Next state

	// Memories: no reset, contents undefined until erased or written
	logic [15:0] flashMem [0:(1<<FL_ADDR_W)-1];
	logic [7:0]  eeMem    [0:(1<<EE_ADDR_W)-1];
	logic [15:0] pageBuf  [0:(1<<FL_WORD_W)-1];
	logic [7:0]  eeBuf    [0:(1<<EE_BYTE_W)-1];

	logic [31:0] rxNew;    // Shift register after this bit
	logic [4:0]  cntNew;   // Bit count after this bit
	logic [7:0]  rdByte;   // Answer byte for a read
	logic        sckRise;  // Synchronised clock rose
	logic        sckFall;  // Synchronised clock fell
	logic        canWrite; // Program and erase allowed now
	logic        pbWe;     // Flash page buffer byte load
	logic        eeWe;     // EEPROM byte write
	logic        eeLdWe;   // EEPROM page buffer load
	logic        eePageWe; // EEPROM page commit

	// ******************************************************
	// Read answer, taken from the first three bytes
	// ******************************************************
	always_comb begin
		logic [7:0]  op;
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic [15:0] word;
		op = rxNew[23:16];
		b2 = rxNew[15:8];
		b3 = rxNew[7:0];
		word = flashMem[{b2[4:0], b3}];
		rdByte = 8'h00;
		case (op)
			OP_POLL: rdByte = {7'h00, state_reg.busy};
			OP_RD_FL_LO: rdByte = word[7:0];
			OP_RD_FL_HI: rdByte = word[15:8];
			OP_RD_EE: rdByte = eeMem[{b2[0], b3}];
			// Second byte picks between the paired fuse reads
			OP_RD_LOCK_FH: rdByte = (b2 == SUB_RD_ALT) ?
				state_reg.fuseHi : state_reg.lockBits;
			OP_RD_FUSE_FE: rdByte = (b2 == SUB_RD_ALT) ?
				state_reg.fuseExt : state_reg.fuseLo;
			OP_RD_SIG: begin
				case (b3[1:0])
					2'h0: rdByte = SIG_BYTE0;
					2'h1: rdByte = SIG_BYTE1;
					2'h2: rdByte = SIG_BYTE2;
					default: rdByte = 8'h00;
				endcase
			end
			OP_RD_CAL: rdByte = CAL_BYTE;
			default: rdByte = 8'h00; // Unknown opcode answers zero
		endcase
	end

	// ******************************************************
	// Framing, decode and operation sequencing
	// ******************************************************
	always_comb begin
		state_next = state_reg;
		pbWe = 1'b0;
		eeWe = 1'b0;
		eeLdWe = 1'b0;
		eePageWe = 1'b0;
		state_next.sckSync = {state_reg.sckSync[1:0], bus.sck};
		state_next.mosiSync = {state_reg.mosiSync[0], bus.mosi};
		state_next.rstSync = {state_reg.rstSync[0], bus.targetRstN};
		sckRise = state_reg.sckSync[1] & ~state_reg.sckSync[2];
		sckFall = ~state_reg.sckSync[1] & state_reg.sckSync[2];
		rxNew = {state_reg.rxSh[30:0], state_reg.mosiSync[1]};
		cntNew = state_reg.bitCnt + 5'd1;
		canWrite = state_reg.enabled && (state_reg.st == DS_IDLE);
		// Self-timed delay counts down to zero and holds
		if (state_reg.waitCnt != 24'h000000) begin
			state_next.waitCnt = state_reg.waitCnt - 24'h000001;
		end
		// Sequencing of the nonvolatile operation in progress
		case (state_reg.st)
			DS_ERASE: begin
				state_next.sweep = state_reg.sweep + 13'h0001;
				if (&state_reg.sweep) begin
					state_next.st = DS_WAIT;
				end
			end
			DS_FLASH: begin
				state_next.sweep = state_reg.sweep + 13'h0001;
				if (&state_reg.sweep[FL_WORD_W-1:0]) begin
					state_next.st = DS_WAIT;
				end
			end
			DS_WAIT: begin
				if (state_reg.waitCnt == 24'h000000) begin
					state_next.st = DS_IDLE;
				end
			end
			default: begin
			end
		endcase
		if (state_reg.rstSync[1]) begin
			// Reset released: framing restarts, enable is lost
			state_next.bitCnt = 5'd0;
			state_next.enabled = 1'b0;
			state_next.txSh = 8'h00;
			state_next.miso = 1'b0;
		end else if (sckRise) begin
			state_next.rxSh = rxNew;
			state_next.bitCnt = cntNew;
			if (cntNew[2:0] == 3'd0) begin
				// After byte three the answer goes out, else an echo
				state_next.txSh = (cntNew == 5'd24) ?
					rdByte : rxNew[7:0];
			end
			if (cntNew == 5'd0) begin
				// Whole instruction framed: execute it
				case (rxNew[31:24])
					OP_SPECIAL: begin
						case (rxNew[23:16])
							SUB_ENABLE: state_next.enabled = 1'b1;
							SUB_ERASE: begin
								if (canWrite) begin
									state_next.st = DS_ERASE;
									state_next.sweep = 13'h0000;
									state_next.waitCnt = 24'(ERASE_WAIT);
									state_next.lockBits = FUSE_RST;
								end
							end
							// Lock bits can only be programmed further
							SUB_WR_LOCK: if (canWrite) begin
								state_next.lockBits =
									state_reg.lockBits & rxNew[7:0];
							end
							SUB_WR_FLO: if (canWrite) begin
								state_next.fuseLo = rxNew[7:0];
							end
							SUB_WR_FHI: if (canWrite) begin
								state_next.fuseHi = rxNew[7:0];
							end
							SUB_WR_FEXT: if (canWrite) begin
								state_next.fuseExt = rxNew[7:0];
							end
							default: begin
							end
						endcase
					end
					OP_LD_FL_LO, OP_LD_FL_HI: pbWe = canWrite;
					OP_WR_FL_PAGE: begin
						if (canWrite) begin
							state_next.st = DS_FLASH;
							state_next.sweep = 13'h0000;
							state_next.flPage = {rxNew[20:16], rxNew[15:14]};
							state_next.waitCnt = 24'(FLASH_WAIT);
						end
					end
					OP_WR_EE: begin
						if (canWrite) begin
							eeWe = 1'b1;
							state_next.st = DS_WAIT;
							state_next.waitCnt = 24'(EEPROM_WAIT);
						end
					end
					OP_LD_EE: begin
						if (canWrite) begin
							eeLdWe = 1'b1;
							state_next.eeLoaded[rxNew[9:8]] = 1'b1;
						end
					end
					OP_WR_EE_PAGE: begin
						if (canWrite) begin
							eePageWe = 1'b1;
							state_next.eeLoaded = 4'h0;
							state_next.st = DS_WAIT;
							state_next.waitCnt = 24'(EEPROM_WAIT);
						end
					end
					default: begin
						// Unknown opcodes and reads change nothing
					end
				endcase
			end
		end else if (sckFall) begin
			state_next.miso = state_reg.txSh[7];
			state_next.txSh = {state_reg.txSh[6:0], 1'b0};
		end
		state_next.busy = (state_next.st != DS_IDLE);
	end

	// ******************************************************
	// State register
	// ******************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.rstSync <= 2'b11;
			state_reg.st <= DS_IDLE;
			state_reg.lockBits <= FUSE_RST;
			state_reg.fuseLo <= FUSE_RST;
			state_reg.fuseHi <= FUSE_RST;
			state_reg.fuseExt <= FUSE_RST;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	// ******************************************************
	// Memory write ports
	// ******************************************************
	always_ff @(posedge clk) begin
		if (clkEn) begin
			if (pbWe) begin
				// Opcode bit three selects the high byte
				if (rxNew[27]) begin
					pageBuf[rxNew[13:8]][15:8] <= rxNew[7:0];
				end else begin
					pageBuf[rxNew[13:8]][7:0] <= rxNew[7:0];
				end
			end
			if (state_reg.st == DS_ERASE) begin
				// One word per cycle; EEPROM index wraps harmlessly
				flashMem[state_reg.sweep] <= 16'hffff;
				eeMem[state_reg.sweep[EE_ADDR_W-1:0]] <= 8'hff;
			end
			if (state_reg.st == DS_FLASH) begin
				flashMem[{state_reg.flPage, state_reg.sweep[5:0]}] <=
					pageBuf[state_reg.sweep[5:0]];
			end
			// Plain overwrite is erase followed by write
			if (eeWe) begin
				eeMem[{rxNew[16], rxNew[15:8]}] <= rxNew[7:0];
			end
			if (eeLdWe) begin
				eeBuf[rxNew[9:8]] <= rxNew[7:0];
			end
			if (eePageWe) begin
				for (int i = 0; i < 4; i++) begin
					if (state_reg.eeLoaded[i]) begin
						eeMem[{rxNew[16], rxNew[15:10], 2'(i)}] <= eeBuf[i];
					end
				end
			end
		end
	end

	// ******************************************************
	// Outputs
	// ******************************************************
	assign bus.miso = state_reg.miso;
	assign progMode = state_reg.enabled;
	assign busy = state_reg.busy;
	assign lockBits = state_reg.lockBits;
	assign fuseLo = state_reg.fuseLo;
	assign fuseHi = state_reg.fuseHi;
	assign fuseExt = state_reg.fuseExt;

endmodule

// >>> verilog/isp_programmer.sv
// Programmer end: shifts four-byte instructions over the serial link
`timescale 1ns/100ps
module isp_programmer
	import isp_pkg::*;
#(
	parameter int ENTRY_WAIT = ENTRY_WAIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	isp_if.prog              bus,
	input  wire logic        releaseTarget,
	input  wire logic        cmdValid,
	input  wire logic [31:0] cmdWord,
	output logic             cmdReady,
	output logic             rspValid,
	output logic [31:0]      rspWord,
	output logic             syncFail
);

	// ******************************************************
	// State
	// ******************************************************
	typedef struct packed {
		logic [1:0]   misoSync; // [0] first stage
		isp_prog_st_t st;
		logic [3:0]   halfCnt;  // Phase timer
		logic [4:0]   bitCnt;   // Bits sent
		logic [31:0]  txSh;
		logic [31:0]  rxSh;
		logic         isEnable; // Current command is programming enable
		logic         sck;
		logic         mosi;
		logic         targetRstN;
		logic [22:0]  entryCnt; // Settle time still to run
		logic         cmdReady;
		logic         rspValid;
		logic [31:0]  rspWord;
		logic         syncFail;
	} isp_prog_state_t;

	isp_prog_state_t state_reg;  // Registered state
	isp_prog_state_t state_next; // Next state

	// ******************************************************
	// Next state
	// ******************************************************
	always_comb begin
		state_next = state_reg;
		state_next.rspValid = 1'b0;
		state_next.cmdReady = 1'b0;
		state_next.misoSync = {state_reg.misoSync[0], bus.miso};
		// Settle timer restarts whenever reset is let go
		if (state_reg.targetRstN) begin
			state_next.entryCnt = 23'(ENTRY_WAIT);
		end else if (state_reg.entryCnt != 23'h000000) begin
			state_next.entryCnt = state_reg.entryCnt - 23'h000001;
		end
		case (state_reg.st)
			PS_SHIFT: begin
				state_next.halfCnt = state_reg.halfCnt + 4'h1;
				if (state_reg.halfCnt == SCK_HALF_CYC - 4'h1) begin
					state_next.halfCnt = 4'h0;
					state_next.sck = ~state_reg.sck;
					if (!state_reg.sck) begin
						state_next.rxSh = {state_reg.rxSh[30:0],
							state_reg.misoSync[1]};
					end else if (state_reg.bitCnt == 5'd31) begin
						state_next.rspValid = 1'b1;
						state_next.rspWord = state_reg.rxSh;
						state_next.st = PS_IDLE;
						// Missing echo: pulse reset to resynchronise
						if (state_reg.isEnable &&
							state_reg.rxSh[15:8] != SUB_ENABLE) begin
							state_next.syncFail = 1'b1;
							state_next.st = PS_PULSE;
							state_next.targetRstN = 1'b1;
						end
					end else begin
						state_next.bitCnt = state_reg.bitCnt + 5'd1;
						state_next.txSh = {state_reg.txSh[30:0], 1'b0};
						state_next.mosi = state_reg.txSh[30];
					end
				end
			end
			PS_PULSE: begin
				state_next.halfCnt = state_reg.halfCnt + 4'h1;
				if (state_reg.halfCnt == RST_PULSE_CYC - 4'h1) begin
					state_next.targetRstN = releaseTarget;
					state_next.st = PS_IDLE;
				end
			end
			default: begin
				state_next.sck = 1'b0;
				state_next.targetRstN = releaseTarget;
				if (cmdValid && state_reg.cmdReady) begin
					// Always all four bytes, echo right or not
					state_next.st = PS_SHIFT;
					state_next.txSh = cmdWord;
					state_next.mosi = cmdWord[31];
					state_next.bitCnt = 5'd0;
					state_next.halfCnt = 4'h0;
					state_next.syncFail = 1'b0;
					state_next.isEnable = (cmdWord[31:24] == OP_SPECIAL) &&
						(cmdWord[23:16] == SUB_ENABLE);
				end else begin
					state_next.cmdReady = !releaseTarget &&
						!state_reg.targetRstN &&
						(state_reg.entryCnt == 23'h000000);
				end
			end
		endcase
		if (state_next.st == PS_PULSE && state_reg.st != PS_PULSE) begin
			state_next.halfCnt = 4'h0;
		end
	end

	// ******************************************************
	// State register; reset holds target reset and clock low
	// ******************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.st <= PS_IDLE;
			// Settle time runs from reset too, so no early first frame
			state_reg.entryCnt <= 23'(ENTRY_WAIT);
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	assign bus.sck = state_reg.sck;
	assign bus.mosi = state_reg.mosi;
	assign bus.targetRstN = state_reg.targetRstN;
	assign cmdReady = state_reg.cmdReady;
	assign rspValid = state_reg.rspValid;
	assign rspWord = state_reg.rspWord;
	assign syncFail = state_reg.syncFail;

endmodule

// >>> verif/isp_link_properties.sv
// Wire checks on the serial programming link between the two ends
`timescale 1ns/100ps
module isp_link_properties #(
	parameter int ENTRY_WAIT = 20 // Quiet cycles before the first frame
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic targetRstN
);
	// ************************************************
	// Helper: cycles since the target reset went low
	// ************************************************
	logic [15:0] quietCnt_reg;  // Saturates, so long sessions never wrap
	logic [15:0] quietCnt_next; // Next count

	// Count while the target sits in programming mode
	always_comb begin
		quietCnt_next = quietCnt_reg;
		if (targetRstN) begin
			quietCnt_next = 16'h0;
		end else if (quietCnt_reg != 16'hffff) begin
			quietCnt_next = quietCnt_reg + 16'h1;
		end
	end

	// Register the count
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			quietCnt_reg <= 16'h0;
		end else begin
			quietCnt_reg <= quietCnt_next;
		end
	end

	// ************************************************
	// Properties
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence sckHigh8; sck [*8]; endsequence   // One high phase
	sequence sckLow8;  !sck [*8]; endsequence  // One low phase

	chk_sck_high_time: assert property
		($rose(sck) |-> sckHigh8 ##1 !sck)
		else $error("serial clock high phase wrong");
	chk_sck_low_time: assert property ($fell(sck) |-> sckLow8)
		else $error("serial clock low phase too short");
	chk_mosi_hold_high: assert property (sck |-> $stable(mosi))
		else $error("data in moved while clock high");
	chk_miso_hold_high: assert property (sck |-> $stable(miso))
		else $error("data out moved while clock high");
	chk_sck_idle_rst: assert property (targetRstN |-> !sck)
		else $error("serial clock active outside programming mode");
	chk_rst_pulse_len: assert property
		($rose(targetRstN) |-> targetRstN [*4])
		else $error("target reset pulse too short");
	chk_entry_quiet: assert property
		($rose(sck) |-> quietCnt_reg >= 16'(ENTRY_WAIT))
		else $error("frame started before entry wait");
	chk_entry_idle: assert property ($fell(targetRstN) |-> sckLow8)
		else $error("serial clock moved right after entry");
endmodule

// >>> verif/testbench.sv
// Self-checking bench joining programmer and target over the link
`timescale 1ns/100ps
module testbench;
	import isp_pkg::*;
	// ************************************************
	// Signals and ends
	// ************************************************
	localparam int ENTRY = 20; // Short entry wait keeps the run brief
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        releaseTarget = 1'b0;
	logic        clkEn = 1'b1; // Low freezes both ends
	logic        cmdValid = 1'b0;
	logic [31:0] cmdWord = 32'h0;
	logic        cmdReady, rspValid, syncFail, progMode, busy;
	logic [31:0] rspWord;
	logic [31:0] rsp;     // Last answer seen
	logic [7:0]  lockBits, fuseLo, fuseHi, fuseExt;
	logic [7:0]  ee [int]; // Expected EEPROM, erased cells absent
	int          errorCnt = 0;
	int          nTests = 0;

	isp_if link ();
	isp_target #(.FLASH_WAIT(100), .EEPROM_WAIT(100), .ERASE_WAIT(100),
		.SIG_BYTE1(8'h3c), .CAL_BYTE(8'h5a)) u_isp_target (
		.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .bus(link.dev),
		.progMode(progMode), .busy(busy), .lockBits(lockBits),
		.fuseLo(fuseLo), .fuseHi(fuseHi), .fuseExt(fuseExt));
	isp_programmer #(.ENTRY_WAIT(ENTRY)) u_isp_programmer (
		.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .bus(link.prog),
		.releaseTarget(releaseTarget), .cmdValid(cmdValid),
		.cmdWord(cmdWord), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspWord(rspWord), .syncFail(syncFail));
	isp_link_properties #(.ENTRY_WAIT(ENTRY)) u_isp_link_properties (
		.clk(clk), .reset_n(reset_n), .sck(link.sck), .mosi(link.mosi),
		.miso(link.miso), .targetRstN(link.targetRstN));

	// 250 MHz clock
	always #2 clk = ~clk;

	// ************************************************
	// Helpers
	// ************************************************
	// Builds one instruction, first byte on top
	function automatic logic [31:0] ins(logic [7:0] a, b, c, d);
		return {a, b, c, d};
	endfunction
	// Expected EEPROM byte, erased cells read ones
	function automatic logic [7:0] eeExp(int a);
		return ee.exists(a) ? ee[a] : 8'hff;
	endfunction
	// Verdict and end of run; a hang counts as a mismatch
	task automatic finishTest(input bit hung);
		if (hung) errorCnt++;
		$display("mismatches=%0d checks=%0d", errorCnt, nTests);
		if (errorCnt == 0 && nTests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Compares one byte
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			errorCnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One whole instruction; the answer lands in rsp
	task automatic send(input logic [31:0] w);
		int i;
		i = 0;
		while (cmdReady !== 1'b1 && i < 4000) begin
			@(posedge clk);
			i++;
		end
		if (i == 4000) finishTest(1'b1);
		cmdValid <= 1'b1;
		cmdWord <= w;
		@(posedge clk);
		cmdValid <= 1'b0;
		i = 0;
		while (rspValid !== 1'b1 && i < 1000) begin
			@(posedge clk);
			i++;
		end
		if (i == 1000) finishTest(1'b1);
		rsp = rspWord;
	endtask
	// Polls until the target is no longer busy
	task automatic waitIdle();
		int i;
		i = 0;
		do send(ins(OP_POLL, 8'h0, 8'h0, 8'h0));
		while (rsp[0] === 1'b1 && ++i < 100);
		check({7'h0, rsp[0]}, 8'h0);
		if (rsp[0] !== 1'b0) finishTest(1'b1);
	endtask
	// Enables programming and checks the echo
	task automatic enableProg();
		send(ins(OP_SPECIAL, SUB_ENABLE, 8'h0, 8'h0));
		check(rsp[15:8], SUB_ENABLE);
		check({7'h0, progMode}, 8'h1);
	endtask
	// Reads one EEPROM byte against the expectation
	task automatic readEe(input logic [8:0] a);
		send(ins(OP_RD_EE, {7'h0, a[8]}, a[7:0], 8'h0));
		check(rsp[7:0], eeExp(int'(a)));
	endtask

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		logic [12:0] wa;
		logic [8:0]  ea;
		logic [7:0]  d, lo, hi;
		logic [31:0] fv;
		logic [7:0]  wsub [4];
		logic [15:0] rsel [4];
		wsub = '{SUB_WR_FLO, SUB_WR_FHI, SUB_WR_FEXT, SUB_WR_LOCK};
		rsel = '{{OP_RD_FUSE_FE, 8'h00}, {OP_RD_LOCK_FH, SUB_RD_ALT},
			{OP_RD_FUSE_FE, SUB_RD_ALT}, {OP_RD_LOCK_FH, 8'h00}};
		void'($urandom(32'h0474752c));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		// A write before enabling is refused
		send(ins(OP_SPECIAL, SUB_WR_FLO, 8'h0, 8'h0));
		check(fuseLo, FUSE_RST);
		enableProg();
		// Erase shows busy first, then ones at the high byte of one random flash word and at one random EEPROM byte
		send(ins(OP_SPECIAL, SUB_ERASE, 8'h0, 8'h0));
		send(ins(OP_POLL, 8'h0, 8'h0, 8'h0));
		check({7'h0, rsp[0]}, 8'h1);
		waitIdle();
		wa = 13'($urandom);
		ea = 9'($urandom);
		send(ins(OP_RD_FL_HI, {3'h0, wa[12:8]}, wa[7:0], 8'h0));
		check(rsp[7:0], 8'hff);
		readEe(ea);
		// Flash page load, commit and read back by word address
		for (int k = 0; k < 3; k++) begin
			wa = 13'($urandom);
			lo = 8'($urandom);
			hi = 8'($urandom);
			send(ins(OP_LD_FL_LO, 8'h0, {2'h0, wa[5:0]}, lo));
			send(ins(OP_LD_FL_HI, 8'h0, {2'h0, wa[5:0]}, hi));
			send(ins(OP_WR_FL_PAGE, {3'h0, wa[12:8]}, wa[7:0], 8'h0));
			waitIdle();
			send(ins(OP_RD_FL_LO, {3'h0, wa[12:8]}, wa[7:0], 8'h0));
			check(rsp[7:0], lo);
			send(ins(OP_RD_FL_HI, {3'h0, wa[12:8]}, wa[7:0], 8'h0));
			check(rsp[7:0], hi);
		end
		// Same EEPROM byte twice: the second value must replace the first
		for (int k = 0; k < 2; k++) begin
			d = 8'($urandom);
			send(ins(OP_WR_EE, {7'h0, ea[8]}, ea[7:0], d));
			// Frozen clock enable must hold the write timer still
			clkEn <= 1'b0;
			repeat (200) @(posedge clk);
			check({7'h0, busy}, 8'h1);
			clkEn <= 1'b1;
			waitIdle();
			ee[int'(ea)] = d;
			readEe(ea);
		end
		// Page mode alters only the loaded byte
		d = 8'($urandom);
		send(ins(OP_LD_EE, 8'h0, {6'h0, ea[1:0] ^ 2'h1}, d));
		send(ins(OP_WR_EE_PAGE, {7'h0, ea[8]}, {ea[7:2], 2'h0}, 8'h0));
		waitIdle();
		ee[int'({ea[8:2], ea[1:0] ^ 2'h1})] = d;
		for (int j = 0; j < 4; j++) readEe({ea[8:2], 2'(j)});
		// Every fuse and lock write, then its read
		for (int k = 0; k < 4; k++) begin
			d = 8'($urandom);
			send(ins(OP_SPECIAL, wsub[k], 8'h0, d));
			waitIdle();
			send(ins(rsel[k][15:8], rsel[k][7:0], 8'h0, 8'h0));
			check(rsp[7:0], d);
			fv = {lockBits, fuseExt, fuseHi, fuseLo};
			check(fv[k*8 +: 8], d);
		end
		send(ins(OP_RD_SIG, 8'h0, 8'h1, 8'h0));
		check(rsp[7:0], 8'h3c);
		send(ins(OP_RD_CAL, 8'h0, 8'h0, 8'h0));
		check(rsp[7:0], 8'h5a);
		// A reset pulse drops the mode; writes refused until re-enabled
		lo = fuseLo;
		releaseTarget <= 1'b1;
		repeat (10) @(posedge clk);
		check({7'h0, progMode}, 8'h0);
		releaseTarget <= 1'b0;
		send(ins(OP_SPECIAL, SUB_WR_FLO, 8'h0, ~lo));
		check(fuseLo, lo);
		enableProg();
		check({7'h0, syncFail}, 8'h0);
		finishTest(1'b0);
	end
endmodule
